// [hdl/serial_port_params.svh]
// Constants shared by both ends of the host serial port
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH
`define CLK_HZ        125_000_000
`define BAUD_MIN      1200
`define BAUD_MAX      921_600
`define OVS           16
`define OVS_MID       4'h7
`define OVS_LAST      4'hf
`define DIV_W         13
`define DIV_RST       13'h0044
`define DIV_MIN       13'(`CLK_HZ / (`OVS * `BAUD_MAX))
`define DIV_MAX       13'(`CLK_HZ / (`OVS * `BAUD_MIN))
`define CH_A          8'h41
`define CH_T          8'h54
`define CH_D          8'h44
`define CH_CR         8'h0d
`define P_LAST        4'hf
`define MSG_CONN_LEN  4'h8
`define MSG_NOC_LEN   4'hb
`define A_CTRL        8'h00
`define A_TXDATA      8'h04
`define A_RXDATA      8'h08
`define A_STATUS      8'h0c
`define A_INT_STAT    8'h10
`define A_INT_MASK    8'h14
`define CTRL_PAR_LSB  13
`define CTRL_STOP_BIT 15
`define CTRL_FLOW_BIT 16
`define CTRL_DTR_BIT  17
`define IRQ_W         6
`endif

// [hdl/serial_port_pkg.sv]
// Types and character-level framing steps for the host serial port
`default_nettype none
package serial_port_pkg;
`include "serial_port_params.svh"

  typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2} parity_e;
  typedef enum logic [2:0] {
    FR_IDLE = 3'h0, FR_START = 3'h1, FR_DATA = 3'h3, FR_PAR = 3'h2, FR_STOP = 3'h6
  } frame_e;
  typedef enum logic [1:0] {M_CMD = 2'h0, M_DIAL = 2'h1, M_DATA = 2'h3, M_ONLINE = 2'h2} mode_e;

  typedef struct packed {
    logic [`DIV_W-1:0] div;
    logic [1:0]        par;
    logic              two_stop;
    logic              flow_en;
    logic              echo_en;
    logic              dsr_cmd;
    logic              ri_poll;
    logic              dte;
  } port_cfg_s;

  typedef struct packed {
    frame_e     st;
    logic [3:0] os;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic       pb;
    logic       line;
  } tx_s;

  typedef struct packed {
    frame_e     st;
    logic [3:0] os;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic       pb;
    logic       perr;
    logic       ferr;
    logic       done;
  } rx_s;

  function automatic logic [`DIV_W-1:0] clamp_div(logic [`DIV_W-1:0] d);
    return (d < `DIV_MIN) ? `DIV_MIN : ((d > `DIV_MAX) ? `DIV_MAX : d);
  endfunction

  function automatic logic [4:0] hex_val(logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
    if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) return {1'b1, c[3:0] + 4'h9};
    return 5'h00;
  endfunction

  // Start, data lsb first, optional parity, one or two stop bits
  function automatic tx_s tx_step(tx_s s, logic tick, logic go, logic [7:0] d, port_cfg_s c);
    tx_s  n;
    logic last;
    n = s;
    last = tick && (s.os == `OVS_LAST);
    if (tick && s.st != FR_IDLE) n.os = s.os + 4'h1;
    case (s.st)
      FR_IDLE: if (go) begin
        n.st = FR_START;
        n.os = 4'h0;
        n.sh = d;
        n.bitn = 3'h0;
        n.pb = (c.par == PAR_ODD);
      end
      FR_START: if (last) n.st = FR_DATA;
      FR_DATA: if (last) begin
        n.pb = s.pb ^ s.sh[0];
        n.sh = {1'b0, s.sh[7:1]};
        n.bitn = s.bitn + 3'h1;
        if (s.bitn == 3'h7) n.st = (c.par == PAR_NONE) ? FR_STOP : FR_PAR;
      end
      FR_PAR: if (last) n.st = FR_STOP;
      FR_STOP: if (last) begin
        if (c.two_stop && s.bitn == 3'h0) n.bitn = 3'h1;
        else n.st = FR_IDLE;
      end
      default: n.st = FR_IDLE;
    endcase
    case (n.st)
      FR_START: n.line = 1'b0;
      FR_DATA:  n.line = n.sh[0];
      FR_PAR:   n.line = n.pb;
      default:  n.line = 1'b1;
    endcase
    return n;
  endfunction

  // Sixteen ticks per bit, samples at mid-bit, checks parity and first stop
  function automatic rx_s rx_step(rx_s s, logic tick, logic line, port_cfg_s c);
    rx_s  n;
    logic last;
    n = s;
    n.done = 1'b0;
    last = tick && (s.os == `OVS_LAST);
    if (tick && s.st != FR_IDLE) n.os = s.os + 4'h1;
    case (s.st)
      FR_IDLE: if (tick && !line) begin
        n.st = FR_START;
        n.os = 4'h0;
        n.perr = 1'b0;
        n.pb = (c.par == PAR_ODD);
      end
      FR_START: if (tick && s.os == `OVS_MID) begin
        n.os = 4'h0;
        n.bitn = 3'h0;
        n.st = line ? FR_IDLE : FR_DATA;
      end
      FR_DATA: if (last) begin
        n.sh = {line, s.sh[7:1]};
        n.pb = s.pb ^ line;
        n.bitn = s.bitn + 3'h1;
        if (s.bitn == 3'h7) n.st = (c.par == PAR_NONE) ? FR_STOP : FR_PAR;
      end
      FR_PAR: if (last) begin
        n.perr = (line != s.pb);
        n.st = FR_STOP;
      end
      FR_STOP: if (last) begin
        n.ferr = !line;
        n.done = 1'b1;
        n.st = FR_IDLE;
      end
      default: n.st = FR_IDLE;
    endcase
    return n;
  endfunction
endpackage
`default_nettype wire

// [hdl/serial_port_if.sv]
// Serial link wires between the module end and the host end
`default_nettype none
interface serial_port_if;
  logic dev_txd;
  logic dev_rxd;
  logic dev_rts_n;
  logic dev_cts_n;
  logic dev_dsr_n;
  logic ring_indicator_out_n;
  modport dev (output dev_txd, dev_rts_n, ring_indicator_out_n,
               input  dev_rxd, dev_cts_n, dev_dsr_n);
  modport host (input  dev_txd, dev_rts_n, ring_indicator_out_n,
                output dev_rxd, dev_cts_n, dev_dsr_n);
endinterface
`default_nettype wire

// [hdl/serial_port_dev.sv]
// Module end of the host serial port: framing, flow control, dial parser
`default_nettype none
// Overview of operation
// - Own RTS output, low means asserted
// - Host drives CTS input, low means asserted
// - RTS and CTS pace each direction
// - Parity none/even/odd, stop bits, flow selectable
// - Bit rate kept within 1200 to 976562
// - Settings load from flash word at start
// - Idle line is logic high
// - Standard async framing and handshake
// - Host drives DSR from its DTR
// - DSR loss drops link or enters online command
// - Ring output flags incoming connection
// - Ring line pollable when enabled
// - Dial command plus twelve hex digits connects
// - Command echo switchable
// - Terminal or communication equipment role
module serial_port_dev
  import serial_port_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  serial_port_if.dev       lk,
  input  wire port_cfg_s   boot_cfg,
  input  wire logic        cfg_load,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic             dial_req,
  output logic [47:0]      dial_addr,
  input  wire logic        dial_done,
  input  wire logic        dial_ok,
  input  wire logic        incoming,
  output logic             link_up,
  output logic             link_drop,
  output logic             rx_error,
  output logic             overrun
);
  typedef struct packed {
    port_cfg_s         cfg;
    logic              booted;
    logic [`DIV_W-1:0] pre;
    logic              tick;
    tx_s               tx;
    rx_s               rx;
    mode_e             mode;
    logic [3:0]        pidx;
    logic [47:0]       addr;
    logic              dial_req;
    logic              msg_busy;
    logic              msg_noc;
    logic [3:0]        midx;
    logic              echo_v;
    logic [7:0]        echo_b;
    logic [1:0]        hcnt;
    logic [1:0][7:0]   hold;
    logic              overrun;
    logic              rx_err;
    logic              drop;
    logic              ri_n;
  } dev_s;

  dev_s r;
  dev_s n;

  function automatic logic [7:0] msg_char(logic noc, logic [3:0] i);
    logic [87:0] s;
    s = noc ? {"NO CARRIER", `CH_CR} : {24'h00_0000, "CONNECT", `CH_CR};
    return noc ? s[87 - 8 * i -: 8] : s[63 - 8 * i -: 8];
  endfunction

  logic       cts_ok;
  logic       go;
  logic [7:0] tx_byte;
  logic [7:0] b;
  logic [4:0] hv;

  always_comb begin
    n = r;
    n.booted = 1'b1;
    n.drop = 1'b0;
    n.rx_err = 1'b0;
    n.overrun = 1'b0;
    if (!r.booted || cfg_load) begin
      n.cfg = boot_cfg;
      n.cfg.div = clamp_div(boot_cfg.div);
    end
    // Oversample tick at sixteen times the bit rate
    n.tick = (r.pre == '0);
    n.pre = n.tick ? r.cfg.div - `DIV_W'(1) : r.pre - `DIV_W'(1);

    // Transmit to host: reply text, then echo, then payload
    cts_ok = !r.cfg.flow_en || !lk.dev_cts_n;
    tx_ready = (r.tx.st == FR_IDLE) && cts_ok && !r.msg_busy && !r.echo_v
               && (r.mode == M_DATA);
    go = (r.tx.st == FR_IDLE) && cts_ok
         && (r.msg_busy || r.echo_v || (r.mode == M_DATA && tx_valid));
    tx_byte = r.msg_busy ? msg_char(r.msg_noc, r.midx) : (r.echo_v ? r.echo_b : tx_data);
    n.tx = tx_step(r.tx, r.tick, go, tx_byte, r.cfg);
    if (go && r.msg_busy) begin
      n.midx = r.midx + 4'h1;
      if (r.midx == (r.msg_noc ? `MSG_NOC_LEN : `MSG_CONN_LEN) - 4'h1) n.msg_busy = 1'b0;
    end else if (go && r.echo_v) begin
      n.echo_v = 1'b0;
    end

    // Receive from host; a two-byte hold absorbs the char already in flight
    n.rx = rx_step(r.rx, r.tick, lk.dev_rxd, r.cfg);
    if (rx_ready && r.hcnt != 2'h0) begin
      n.hold[0] = r.hold[1];
      n.hcnt = r.hcnt - 2'h1;
    end
    b = r.rx.sh;
    hv = hex_val(b);
    if (r.rx.done) begin
      if (r.rx.perr || r.rx.ferr) begin
        n.rx_err = 1'b1;
      end else if (r.mode == M_DATA) begin
        if (n.hcnt == 2'h2) begin
          n.overrun = 1'b1;
        end else begin
          n.hold[n.hcnt[0]] = b;
          n.hcnt = n.hcnt + 2'h1;
        end
      end else begin
        if (r.cfg.echo_en) begin
          n.echo_v = 1'b1;
          n.echo_b = b;
        end
        n.pidx = (b == `CH_A) ? 4'h1 : 4'h0;
        case (r.pidx)
          4'h1: if (b == `CH_T) n.pidx = 4'h2;
          4'h2: if (b == `CH_D) n.pidx = 4'h3;
          `P_LAST: if (b == `CH_CR && r.mode == M_CMD) begin
            n.dial_req = 1'b1;
            n.mode = M_DIAL;
          end
          default: if (r.pidx != 4'h0 && hv[4]) begin
            n.pidx = r.pidx + 4'h1;
            n.addr = {r.addr[43:0], hv[3:0]};
          end
        endcase
      end
    end

    // Dial outcome becomes a reply to the host
    if (r.mode == M_DIAL && dial_done) begin
      n.dial_req = 1'b0;
      n.mode = dial_ok ? M_DATA : M_CMD;
      n.msg_busy = 1'b1;
      n.msg_noc = !dial_ok;
      n.midx = 4'h0;
    end

    // Terminal role has no DSR or ring duties
    if (!r.cfg.dte) begin
      if (r.mode == M_DATA && lk.dev_dsr_n) begin
        if (r.cfg.dsr_cmd) begin
          n.mode = M_ONLINE;
        end else begin
          n.mode = M_CMD;
          n.drop = 1'b1;
          n.msg_busy = 1'b1;
          n.msg_noc = 1'b1;
          n.midx = 4'h0;
        end
      end else if (r.mode == M_ONLINE && !lk.dev_dsr_n) begin
        n.mode = M_DATA;
      end
    end
    n.ri_n = !(incoming && r.cfg.ri_poll && !r.cfg.dte);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.cfg.div <= `DIV_RST;
      r.tx.line <= 1'b1;
      r.ri_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign lk.dev_txd = r.tx.line;
  // Deasserted while any byte waits, so the in-flight one still fits
  assign lk.dev_rts_n = r.cfg.flow_en && (r.hcnt != 2'h0);
  assign lk.ring_indicator_out_n = r.ri_n;
  assign rx_data = r.hold[0];
  assign rx_valid = (r.hcnt != 2'h0);
  assign dial_req = r.dial_req;
  assign dial_addr = r.addr;
  assign link_up = (r.mode == M_DATA) || (r.mode == M_ONLINE);
  assign link_drop = r.drop;
  assign rx_error = r.rx_err;
  assign overrun = r.overrun;
endmodule // serial_port_dev
`default_nettype wire

// [hdl/serial_port_host.sv]
// Host end of the serial port: APB-controlled UART with interrupts
`default_nettype none
module serial_port_host
  import serial_port_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  serial_port_if.host      lk,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  typedef struct packed {
    port_cfg_s         cfg;
    logic              dtr;
    logic [`DIV_W-1:0] pre;
    logic              tick;
    tx_s               tx;
    rx_s               rx;
    logic              txv;
    logic [7:0]        txb;
    logic              rxv;
    logic [7:0]        rxb;
    logic              ri_d;
    logic [`IRQ_W-1:0] stat;
    logic [`IRQ_W-1:0] mask;
    logic [31:0]       prdata;
  } host_s;

  host_s r;
  host_s n;

  logic              acc;
  logic              wr;
  logic              hit;
  logic              go;
  logic [`IRQ_W-1:0] ev;

  always_comb begin
    n = r;
    acc = psel && penable;
    wr = acc && pwrite;
    hit = (paddr == `A_CTRL) || (paddr == `A_TXDATA) || (paddr == `A_RXDATA)
          || (paddr == `A_STATUS) || (paddr == `A_INT_STAT) || (paddr == `A_INT_MASK);
    ev = '0;
    n.tick = (r.pre == '0);
    n.pre = n.tick ? r.cfg.div - `DIV_W'(1) : r.pre - `DIV_W'(1);

    // Read data is captured in the setup cycle
    if (psel && !penable) begin
      case (paddr)
        `A_CTRL:     n.prdata = {14'h0000, r.dtr, r.cfg.flow_en, r.cfg.two_stop,
                                 r.cfg.par, r.cfg.div};
        `A_RXDATA:   n.prdata = {24'h00_0000, r.rxb};
        `A_STATUS:   n.prdata = {27'h000_0000, !lk.dev_rts_n, !lk.ring_indicator_out_n,
                                 r.tx.st != FR_IDLE, r.txv, r.rxv};
        `A_INT_STAT: n.prdata = {26'h000_0000, r.stat};
        `A_INT_MASK: n.prdata = {26'h000_0000, r.mask};
        default:     n.prdata = 32'h0000_0000;
      endcase
    end
    if (wr && paddr == `A_CTRL) begin
      n.cfg.div = clamp_div(pwdata[`DIV_W-1:0]);
      n.cfg.par = pwdata[`CTRL_PAR_LSB +: 2];
      n.cfg.two_stop = pwdata[`CTRL_STOP_BIT];
      n.cfg.flow_en = pwdata[`CTRL_FLOW_BIT];
      n.dtr = pwdata[`CTRL_DTR_BIT];
    end
    if (wr && paddr == `A_INT_MASK) n.mask = pwdata[`IRQ_W-1:0];
    // A write while a byte is still pending is ignored
    if (wr && paddr == `A_TXDATA && !r.txv) begin
      n.txv = 1'b1;
      n.txb = pwdata[7:0];
    end

    // Device RTS low grants our transmitter
    go = (r.tx.st == FR_IDLE) && r.txv && (!r.cfg.flow_en || !lk.dev_rts_n);
    if (go) n.txv = 1'b0;
    n.tx = tx_step(r.tx, r.tick, go, r.txb, r.cfg);
    ev[5] = (r.tx.st == FR_STOP) && (n.tx.st == FR_IDLE);

    if (acc && !pwrite && paddr == `A_RXDATA) n.rxv = 1'b0;
    n.rx = rx_step(r.rx, r.tick, lk.dev_txd, r.cfg);
    if (r.rx.done) begin
      ev[1] = r.rx.perr;
      ev[2] = r.rx.ferr;
      ev[3] = n.rxv;
      ev[0] = 1'b1;
      n.rxv = 1'b1;
      n.rxb = r.rx.sh;
    end
    n.ri_d = !lk.ring_indicator_out_n;
    ev[4] = n.ri_d && !r.ri_d;

    // New events win over a write-one clear in the same cycle
    n.stat = r.stat & ~((wr && paddr == `A_INT_STAT) ? pwdata[`IRQ_W-1:0] : '0);
    n.stat = n.stat | ev;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.cfg.div <= `DIV_RST;
      r.tx.line <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign lk.dev_rxd = r.tx.line;
  assign lk.dev_cts_n = r.cfg.flow_en && r.rxv;
  assign lk.dev_dsr_n = !r.dtr;
  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign irq = |(r.stat & r.mask);
endmodule // serial_port_host
`default_nettype wire

// [verif/serial_port_props.sv]
// Concurrent checks on the serial link and the module user side
`default_nettype none
module serial_port_props #(
  parameter int DIV = 8
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        dev_txd,
  input wire logic        dev_rxd,
  input wire logic        dev_rts_n,
  input wire logic        dev_dsr_n,
  input wire logic        ring_indicator_out_n,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic [7:0]  rx_data,
  input wire logic        link_drop,
  input wire logic        link_up,
  input wire logic        dial_req,
  input wire logic        dial_done,
  input wire logic [47:0] dial_addr,
  input wire logic        incoming
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LO_MIN = 15 * DIV;
  localparam int LO_MAX = 160 * DIV;
  logic [15:0] lo_tx_r;
  logic [15:0] lo_rx_r;

  // Low runs; start bit may lose up to one tick of phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lo_tx_r <= 16'h0000;
      lo_rx_r <= 16'h0000;
    end else begin
      lo_tx_r <= dev_txd ? 16'h0000 : lo_tx_r + 16'h0001;
      lo_rx_r <= dev_rxd ? 16'h0000 : lo_rx_r + 16'h0001;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_idle_after_reset: assert property (
    $fell(rst) |-> dev_txd && dev_rxd && ring_indicator_out_n)
    else $error("link not idle after reset");
  chk_tx_low_run: assert property (
    $rose(dev_txd) |-> lo_tx_r >= LO_MIN && lo_tx_r <= LO_MAX)
    else $error("module line low run out of range");
  chk_rx_low_run: assert property (
    $rose(dev_rxd) |-> lo_rx_r >= LO_MIN && lo_rx_r <= LO_MAX)
    else $error("host line low run out of range");
  chk_rx_hold_stable: assert property (
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("received byte not held");
  chk_rts_when_held: assert property (
    rx_valid ##1 rx_valid |-> dev_rts_n)
    else $error("request to send kept while byte held");
  chk_drop_on_dsr: assert property (
    link_drop |-> dev_dsr_n ##1 !link_drop ##[0:2] !link_up)
    else $error("drop pulse without ready loss");
  chk_dial_hold: assert property (
    dial_req && !dial_done |=> dial_req && $stable(dial_addr))
    else $error("dial request not held");
  chk_ring_cause: assert property (
    !ring_indicator_out_n |-> incoming || $past(incoming) || $past(incoming, 2))
    else $error("ring without incoming call");
  chk_ring_soon: assert property (
    $rose(incoming) |-> ##[1:4] !ring_indicator_out_n)
    else $error("ring late");
endmodule // serial_port_props
`default_nettype wire

// [verif/test_host_serial_port_with_modem_control.sv]
// Bench joining module end and host end of the serial port
`default_nettype none
`include "serial_port_params.svh"
module test_host_serial_port_with_modem_control
  import serial_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CTRL_RUN = 32'h0003_2008; // Div 8, even, flow, dtr
  logic        clk, rst, cfg_load, tx_valid, tx_ready, rx_valid, rx_ready, slv;
  logic        dial_req, dial_done, dial_ok, incoming, link_up, link_drop, rx_error, overrun;
  logic        psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  tx_data, rx_data, paddr, c;
  logic [31:0] pwdata, prdata, rd;
  logic [47:0] dial_addr;
  port_cfg_s   boot_cfg;
  int          err_count, checked;

  serial_port_if lk ();
  serial_port_dev u_serial_port_dev (.clk(clk), .rst(rst), .lk(lk), .boot_cfg(boot_cfg),
    .cfg_load(cfg_load), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .dial_req(dial_req),
    .dial_addr(dial_addr), .dial_done(dial_done), .dial_ok(dial_ok), .incoming(incoming),
    .link_up(link_up), .link_drop(link_drop), .rx_error(rx_error), .overrun(overrun));
  serial_port_host u_serial_port_host (.clk(clk), .rst(rst), .lk(lk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  serial_port_props #(.DIV(8)) u_serial_port_props (.clk(clk), .rst(rst),
    .dev_txd(lk.dev_txd), .dev_rxd(lk.dev_rxd), .dev_rts_n(lk.dev_rts_n),
    .dev_dsr_n(lk.dev_dsr_n), .ring_indicator_out_n(lk.ring_indicator_out_n),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .link_drop(link_drop),
    .link_up(link_up), .dial_req(dial_req), .dial_done(dial_done), .dial_addr(dial_addr),
    .incoming(incoming));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic hang();
    err_count++;
    $display("ERROR %0t wait limit reached", $time);
    complete_run();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t mismatch got %h expected %h", $time, seen, exp);
    end
  endtask

  // Zero wait states expected, but the wait stays open to a slower slave
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      if (n++ == 50) hang();
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_rx();
    rd = 32'h0000_0000;
    for (int n = 0; rd[0] !== 1'b1; n++) begin
      if (n == 3000) hang();
      apb(1'b0, `A_STATUS, 32'h0000_0000);
    end
  endtask

  task automatic rx_host(output logic [7:0] b);
    wait_rx();
    apb(1'b0, `A_RXDATA, 32'h0000_0000);
    b = rd[7:0];
  endtask

  // Offer one payload byte to the module end and hold it until taken
  task automatic dev_send(input logic [7:0] b);
    tx_data <= b;
    tx_valid <= 1'b1;
    for (int n = 0; n <= 5000; n++) begin
      if (n == 5000) hang();
      @(posedge clk);
      if (tx_ready === 1'b1) break;
    end
    tx_valid <= 1'b0;
  endtask

  task automatic t_regs();
    apb(1'b0, `A_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0044);
    apb(1'b0, `A_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0010);
    apb(1'b0, 8'h20, 32'h0000_0000);
    check(32'(slv), 32'h0000_0001);
    apb(1'b1, `A_CTRL, CTRL_RUN);
    apb(1'b0, `A_CTRL, 32'h0000_0000);
    check(rd, CTRL_RUN);
    check(32'(lk.dev_dsr_n), 32'h0000_0000);
  endtask

  task automatic t_dial();
    string s;
    s = "ATD0123456789AB\r";
    for (int i = 0; i < s.len(); i++) begin
      apb(1'b1, `A_TXDATA, 32'(s[i]));
      rx_host(c);
      check(32'(c), 32'(s[i]));
    end
    for (int n = 0; dial_req !== 1'b1; n++) begin
      if (n == 3000) hang();
      @(posedge clk);
    end
    check(dial_addr[47:16], 32'h0123_4567);
    check(32'(dial_addr[15:0]), 32'h0000_89ab);
    dial_ok <= 1'b1;
    dial_done <= 1'b1;
    @(posedge clk);
    dial_done <= 1'b0;
    s = "CONNECT\r";
    for (int i = 0; i < s.len(); i++) begin
      rx_host(c);
      check(32'(c), 32'(s[i]));
    end
    check(32'(link_up), 32'h0000_0001);
  endtask

  // Host holds its byte unread, so the second module byte must wait
  task automatic t_data();
    int bad;
    bad = 0;
    apb(1'b1, `A_INT_STAT, 32'h0000_003f);
    apb(1'b1, `A_INT_MASK, 32'h0000_0001);
    dev_send(8'h3c);
    wait_rx();
    check(32'(lk.dev_cts_n), 32'h0000_0001);
    check(32'(irq), 32'h0000_0001);
    // Second byte stays offered while the host reads the first
    fork
      dev_send(8'h5a);
      begin
        for (int n = 0; n < 2000; n++) begin
          @(posedge clk);
          if (lk.dev_txd !== 1'b1) bad++;
        end
        check(bad, 32'h0000_0000);
        rx_host(c);
        check(32'(c), 32'h0000_003c);
      end
    join
    apb(1'b1, `A_INT_STAT, 32'h0000_0001);
    check(32'(irq), 32'h0000_0000);
    apb(1'b1, `A_INT_MASK, 32'h0000_0000);
    rx_host(c);
    check(32'(c), 32'h0000_005a);
    apb(1'b0, `A_INT_STAT, 32'h0000_0000);
    check({rd[0], irq}, 32'h0000_0002);
    apb(1'b1, `A_TXDATA, 32'h0000_00c3);
    for (int n = 0; rx_valid !== 1'b1; n++) begin
      if (n == 3000) hang();
      @(posedge clk);
    end
    check(32'(rx_data), 32'h0000_00c3);
    repeat (4) @(posedge clk);
    check({rx_valid, lk.dev_rts_n}, 32'h0000_0003);
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
    repeat (4) @(posedge clk);
    check({rx_valid, lk.dev_rts_n}, 32'h0000_0000);
  endtask

  // Host flow off ignores module RTS, so the third byte finds the hold full
  task automatic t_overrun();
    int seen;
    seen = 0;
    apb(1'b1, `A_CTRL, 32'h0002_2008);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `A_TXDATA, 32'h0000_0061 + 32'(i));
      rd = 32'h0000_0002;
      for (int n = 0; rd[1] !== 1'b0; n++) begin
        if (n == 3000) hang();
        apb(1'b0, `A_STATUS, 32'h0000_0000);
      end
    end
    for (int n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (overrun === 1'b1) seen++;
    end
    check(seen, 32'h0000_0001);
    check(32'(rx_data), 32'h0000_0061);
    rx_ready <= 1'b1;
    repeat (2) @(posedge clk);
    rx_ready <= 1'b0;
    @(posedge clk);
    check(32'(rx_valid), 32'h0000_0000);
    apb(1'b1, `A_CTRL, CTRL_RUN);
  endtask

  // Ready loss with online command set keeps the link, payload paused
  task automatic t_online();
    int seen;
    seen = 0;
    boot_cfg.dsr_cmd <= 1'b1;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    apb(1'b1, `A_CTRL, 32'h0001_2008);
    repeat (8) begin
      @(posedge clk);
      if (link_drop === 1'b1) seen++;
    end
    check(seen, 32'h0000_0000);
    check({link_up, tx_ready}, 32'h0000_0002);
    apb(1'b1, `A_CTRL, CTRL_RUN);
    @(posedge clk);
    check({link_up, tx_ready}, 32'h0000_0003);
    boot_cfg.dsr_cmd <= 1'b0;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
  endtask

  // Host switched to odd parity, module still even
  task automatic t_parity();
    int seen;
    seen = 0;
    apb(1'b1, `A_CTRL, 32'h0003_4008);
    apb(1'b1, `A_TXDATA, 32'h0000_000f);
    for (int n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (rx_error === 1'b1) seen++;
    end
    check(seen, 32'h0000_0001);
    check(32'(rx_valid), 32'h0000_0000);
    apb(1'b1, `A_CTRL, CTRL_RUN);
  endtask

  task automatic t_ring();
    incoming <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'(lk.ring_indicator_out_n), 32'h0000_0000);
    apb(1'b0, `A_STATUS, 32'h0000_0000);
    check(32'(rd[3]), 32'h0000_0001);
    incoming <= 1'b0;
    repeat (4) @(posedge clk);
    check(32'(lk.ring_indicator_out_n), 32'h0000_0001);
  endtask

  task automatic t_drop();
    int seen;
    seen = 0;
    apb(1'b1, `A_CTRL, 32'h0001_2008);
    check(32'(lk.dev_dsr_n), 32'h0000_0001);
    for (int n = 0; n < 200; n++) begin
      @(posedge clk);
      if (link_drop === 1'b1) seen++;
    end
    check(seen, 32'h0000_0001);
    check(32'(link_up), 32'h0000_0000);
    rx_host(c);
    check(32'(c), 32'h0000_004e);
  endtask

  initial begin
    rst = 1'b1;
    {cfg_load, tx_valid, rx_ready, dial_done, dial_ok, incoming} = 6'h00;
    {psel, penable, pwrite} = 3'h0;
    tx_data = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    err_count = 0;
    checked = 0;
    // Boot word: div 8, even parity, one stop, flow, echo, drop on loss, ring poll
    boot_cfg = '{div: 13'h0008, par: PAR_EVEN, two_stop: 1'b0, flow_en: 1'b1,
                 echo_en: 1'b1, dsr_cmd: 1'b0, ri_poll: 1'b1, dte: 1'b0};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_regs();
    t_dial();
    t_data();
    t_overrun();
    t_parity();
    t_ring();
    t_online();
    t_drop();
    complete_run();
  end
endmodule // test_host_serial_port_with_modem_control
`default_nettype wire
